// ==== logic/sram_host.sv ====
`timescale 1ns/100ps
// Contract
// (RULE_01) With the width strap high the memory holds 1M sixteen-bit words with both lanes.
// (RULE_02) With the strap low it holds 2M bytes, top data pin as extra address MSB, lanes unused.
// (RULE_03) Either chip select inactive, or both lane enables high, deselects the memory.
// (RULE_04) A write lasts only while strobe, both chip selects and a lane enable are all active.
// (RULE_05) Write data setup and hold count from whichever edge ends the write overlap.
// (RULE_06) Read data is valid 55 ns or 70 ns after a stable address while selected.
// (RULE_07) Old read data holds at least 10 ns after an address change.
// (RULE_08) Data is valid 25 ns or 35 ns after output enable falls.
// (RULE_09) A lane's data is valid 55 ns or 70 ns after its lane enable falls.
// (RULE_10) The write address is stable at least 40 ns or 60 ns before write end.
// (RULE_11) Write data is valid at least 25 ns or 30 ns before write end, no hold needed.
// (RULE_12) After data retention the controller waits 55 ns or 70 ns before an access.
// (RULE_13) The write strobe stays high through every read.
// (RULE_14) The memory floats its data pins while output enable is high.
// (RULE_15) Upper lane enable gates bits 15..8, lower lane enable bits 7..0.
// (RULE_16) The controller drives data only with output enable high; byte-mode reads still drive the bus (top pin as address MSB) with it low.
module sram_host #(
  parameter bit SLOW_GRADE = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WIDE_MODE,
  input wire logic RETENTION_EXIT,
  input wire sram_host_pkg::req_s REQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  output logic [sram_host_pkg::DATA_W-1:0] RDATA,
  output logic RDATA_VALID,
  output sram_host_pkg::pins_s PINS,
  input wire logic [sram_host_pkg::DATA_W-1:0] DQ_IN
);

  // ---------------------------------------------------------------------------
  // Cycle counts derived from the grade
  // ---------------------------------------------------------------------------
  localparam int G = SLOW_GRADE ? 1 : 0;
  // Read waits the address access time alone, which covers the output-enable and lane access times.
  localparam logic [sram_host_pkg::CNT_W-1:0] READ_CYC =
    sram_host_pkg::min_cycles(sram_host_pkg::ADDRESS_ACCESS_TIME_NS[G]); // RULE_06 RULE_08 RULE_09
  localparam int WR_NS = sram_host_pkg::ADDRESS_SETUP_TO_WRITE_END_NS[G] >
    sram_host_pkg::WRITE_DATA_SETUP_NS[G] ? sram_host_pkg::ADDRESS_SETUP_TO_WRITE_END_NS[G] :
    sram_host_pkg::WRITE_DATA_SETUP_NS[G];
  localparam logic [sram_host_pkg::CNT_W-1:0] WRITE_CYC = sram_host_pkg::min_cycles(WR_NS);
  localparam logic [sram_host_pkg::CNT_W-1:0] TURN_CYC =
    sram_host_pkg::min_cycles(sram_host_pkg::OUTPUT_OFF_NS[G]);
  localparam logic [sram_host_pkg::CNT_W-1:0] RECOVER_CYC =
    sram_host_pkg::min_cycles(sram_host_pkg::RECOVERY_NS[G]);

  // ---------------------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_b;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  logic [sram_host_pkg::DATA_W+1:0] sync_q;
  sram_sync2 #(.W(sram_host_pkg::DATA_W + 2)) u_sync (
    .CLK(CLK),
    .rst_b(rst_b),
    .d({WIDE_MODE, RETENTION_EXIT, DQ_IN}),
    .q(sync_q)
  );
  logic wide_s;
  logic ret_exit_s;
  logic [sram_host_pkg::DATA_W-1:0] dq_s;
  assign wide_s = sync_q[sram_host_pkg::DATA_W+1];
  assign ret_exit_s = sync_q[sram_host_pkg::DATA_W];
  assign dq_s = sync_q[sram_host_pkg::DATA_W-1:0];

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sram_host_pkg::state_e state;
    logic [sram_host_pkg::CNT_W-1:0] cnt;
    sram_host_pkg::pins_s pins;
    logic ready;
    logic [sram_host_pkg::DATA_W-1:0] rdata;
    logic rvalid;
    logic [1:0] lanes_n;
  } host_s;

  host_s st_reg;
  host_s st_next;

  localparam sram_host_pkg::pins_s PINS_IDLE = '{
    chip_select_low_n: 1'b1, chip_select_high: 1'b0, write_n: 1'b1,
    output_enable_n: 1'b1, upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1,
    addr: '0, dout: '0, data_oe: 1'b0};

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    if (ret_exit_s) begin
      // Supply just left retention: hold off all access for the recovery time.
      st_next.state = sram_host_pkg::ST_RECOVER; // RULE_12
      st_next.cnt = RECOVER_CYC;
      st_next.ready = 1'b0;
      st_next.pins = PINS_IDLE;
    end else begin
      case (st_reg.state)
        sram_host_pkg::ST_IDLE: begin
          st_next.pins = PINS_IDLE; // RULE_03
          st_next.ready = 1'b1;
          if (REQ_VALID && st_reg.ready) begin
            st_next.ready = 1'b0;
            st_next.pins.chip_select_low_n = 1'b0;
            st_next.pins.chip_select_high = 1'b1;
            if (wide_s) begin
              st_next.pins.addr = REQ.addr[sram_host_pkg::ADDR_W-1:0]; // RULE_01
              st_next.lanes_n = REQ.lanes_n; // RULE_15
              st_next.pins.dout = REQ.wdata;
            end else begin
              // Byte mode: low address bits on the address pins, MSB on the top data pin.
              st_next.pins.addr = REQ.addr[sram_host_pkg::ADDR_W-1:0]; // RULE_02
              st_next.lanes_n = sram_host_pkg::LANES_BOTH;
              st_next.pins.dout = {REQ.addr[sram_host_pkg::ADDR_W],
                {(sram_host_pkg::DATA_W-sram_host_pkg::BYTE_W-1){1'b0}},
                REQ.wdata[sram_host_pkg::BYTE_W-1:0]};
            end
            st_next.pins.upper_lane_enable_n = st_next.lanes_n[1];
            st_next.pins.lower_lane_enable_n = st_next.lanes_n[0];
            if (REQ.write) begin
              // Output enable stays high, so the memory floats and we may drive.
              st_next.pins.output_enable_n = 1'b1; // RULE_16
              st_next.pins.data_oe = 1'b1;
              st_next.pins.write_n = 1'b0; // RULE_04
              st_next.state = sram_host_pkg::ST_WRITE;
              st_next.cnt = WRITE_CYC;
            end else begin
              st_next.pins.write_n = 1'b1; // RULE_13
              st_next.pins.output_enable_n = 1'b0;
              st_next.pins.data_oe = !wide_s;
              st_next.state = sram_host_pkg::ST_READ;
              st_next.cnt = READ_CYC;
            end
          end
        end
        sram_host_pkg::ST_READ: begin
          st_next.cnt = st_reg.cnt - sram_host_pkg::CNT_ONE;
          if (st_reg.cnt == sram_host_pkg::CNT_ONE) begin
            // Data sampled through the synchroniser, so it is two cycles older.
            st_next.state = sram_host_pkg::ST_TURN;
            st_next.cnt = TURN_CYC + sram_host_pkg::CNT_ONE + sram_host_pkg::CNT_ONE;
          end
        end
        sram_host_pkg::ST_TURN: begin
          st_next.cnt = st_reg.cnt - sram_host_pkg::CNT_ONE;
          if (st_reg.cnt == TURN_CYC) begin
            st_next.rdata = wide_s ? dq_s :
              {{(sram_host_pkg::DATA_W-sram_host_pkg::BYTE_W){1'b0}},
               dq_s[sram_host_pkg::BYTE_W-1:0]};
            st_next.rvalid = 1'b1;
            st_next.pins = PINS_IDLE;
          end
          if (st_reg.cnt == sram_host_pkg::CNT_ONE) begin
            st_next.state = sram_host_pkg::ST_IDLE;
          end
        end
        sram_host_pkg::ST_WRITE: begin
          st_next.cnt = st_reg.cnt - sram_host_pkg::CNT_ONE;
          if (st_reg.cnt == sram_host_pkg::CNT_ONE) begin
            // Strobe, low select and lane enables rise as the high select falls; data and address stay this edge.
            st_next.pins.write_n = 1'b1; // RULE_05 RULE_10 RULE_11
            st_next.pins.chip_select_low_n = 1'b1;
            st_next.pins.chip_select_high = 1'b0;
            st_next.pins.upper_lane_enable_n = 1'b1;
            st_next.pins.lower_lane_enable_n = 1'b1;
            st_next.state = sram_host_pkg::ST_IDLE;
          end
        end
        sram_host_pkg::ST_RECOVER: begin
          st_next.cnt = st_reg.cnt - sram_host_pkg::CNT_ONE;
          if (st_reg.cnt == sram_host_pkg::CNT_ONE) begin
            st_next.state = sram_host_pkg::ST_IDLE;
          end
        end
        default: begin
          st_next.state = sram_host_pkg::ST_IDLE;
          st_next.pins = PINS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{state: sram_host_pkg::ST_IDLE, cnt: sram_host_pkg::CNT_ZERO,
                  pins: PINS_IDLE, ready: 1'b0, rdata: '0, rvalid: 1'b0,
                  lanes_n: sram_host_pkg::LANES_NONE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign PINS = st_reg.pins;
  assign REQ_READY = st_reg.ready;
  assign RDATA = st_reg.rdata;
  assign RDATA_VALID = st_reg.rvalid;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  read_strobe_high_a : assert property ( // RULE_13
    @(posedge CLK) disable iff (!rst_b)
    !PINS.output_enable_n |-> PINS.write_n)
    else $error("write strobe low during read");

  no_drive_oe_a : assert property ( // RULE_16
    @(posedge CLK) disable iff (!rst_b)
    (PINS.data_oe && !PINS.write_n) |-> PINS.output_enable_n)
    else $error("host drives data while memory may drive");

  // The strobe must have been low, on the same address, WRITE_CYC cycles before it rises.
  write_length_a : assert property ( // RULE_10
    @(posedge CLK) disable iff (!rst_b)
    $rose(PINS.write_n) |-> !$past(PINS.write_n, WRITE_CYC) &&
      ($past(PINS.addr, WRITE_CYC) == PINS.addr))
    else $error("write pulse not held for setup time");

  write_data_stable_a : assert property ( // RULE_11
    @(posedge CLK) disable iff (!rst_b)
    (!PINS.write_n && !$fell(PINS.write_n)) |-> $stable(PINS.dout))
    else $error("write data changed inside write");

  write_ends_all_a : assert property ( // RULE_04
    @(posedge CLK) disable iff (!rst_b)
    $rose(PINS.write_n) |-> PINS.chip_select_low_n && !PINS.chip_select_high)
    else $error("write end left chip selected");

  read_wait_a : assert property ( // RULE_06
    @(posedge CLK) disable iff (!rst_b)
    $fell(PINS.output_enable_n) |-> !PINS.output_enable_n[*2])
    else $error("read shorter than access time");

  recover_wait_a : assert property ( // RULE_12
    @(posedge CLK) disable iff (!rst_b)
    ret_exit_s |=> !REQ_READY[*2])
    else $error("access allowed during recovery");

  recover_deselect_a : assert property ( // RULE_12
    @(posedge CLK) disable iff (!rst_b)
    (st_reg.state == sram_host_pkg::ST_RECOVER) |->
      PINS.chip_select_low_n && !PINS.chip_select_high)
    else $error("memory selected during recovery");

  idle_deselect_a : assert property ( // RULE_03
    @(posedge CLK) disable iff (!rst_b)
    (st_reg.state == sram_host_pkg::ST_IDLE) |-> PINS.chip_select_low_n)
    else $error("memory selected while idle");

endmodule

// ==== logic/sram_host_pkg.sv ====
package sram_host_pkg;

  // ---------------------------------------------------------------------------
  // Widths and fixed values
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 5;
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [1:0] LANES_NONE = 2'h3;
  localparam logic [1:0] LANES_BOTH = 2'h0;

  // ---------------------------------------------------------------------------
  // Timing in ns, fast grade first, slow grade second
  // ---------------------------------------------------------------------------
  localparam int ADDRESS_ACCESS_TIME_NS[2] = '{55, 70};
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS[2] = '{25, 35};
  localparam int LANE_ENABLE_ACCESS_TIME_NS[2] = '{55, 70};
  localparam int ADDRESS_SETUP_TO_WRITE_END_NS[2] = '{40, 60};
  localparam int WRITE_DATA_SETUP_NS[2] = '{25, 30};
  localparam int RECOVERY_NS[2] = '{55, 70};
  localparam int OUTPUT_OFF_NS[2] = '{20, 25};

  // Least times round up to whole cycles, never under one.
  function automatic logic [CNT_W-1:0] min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_TURN = 3'h3,
    ST_WRITE = 3'h2,
    ST_RECOVER = 3'h6
  } state_e;

  typedef struct packed {
    logic chip_select_low_n;
    logic chip_select_high;
    logic write_n;
    logic output_enable_n;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic data_oe;
  } pins_s;

  typedef struct packed {
    logic write;
    logic [ADDR_W:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes_n;
  } req_s;

endpackage

// ==== logic/sram_sync2.sv ====
`timescale 1ns/100ps
module sram_sync2 #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge CLK or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule

// ==== bench/sram_dev.sv ====
`timescale 1ns/100ps
module sram_dev #(
  parameter bit SLOW = 1'b0
) (
  input wire sram_host_pkg::pins_s p,
  input wire logic wide,
  output logic [15:0] dq,
  output logic [15:0] dq_en,
  output int errs
);
  localparam int ACC = sram_host_pkg::ADDRESS_ACCESS_TIME_NS[SLOW];
  localparam int OEA = sram_host_pkg::OUTPUT_ENABLE_ACCESS_TIME_NS[SLOW];
  localparam int AW = sram_host_pkg::ADDRESS_SETUP_TO_WRITE_END_NS[SLOW];
  localparam int SD = sram_host_pkg::WRITE_DATA_SETUP_NS[SLOW];
  logic [15:0] mem [int];
  sram_host_pkg::pins_s pd;
  logic [15:0] word, late, held;
  logic sel, rd, sl, ol, ul, ll, ok, v;
  // Two-state so that the unknown pins before reset give no false write end.
  bit wr;
  int nw = 0;
  int k;
  real ta = 0.0;
  real td = 0.0;
  // -------------------------------------------------------------------------
  // Byte mode keeps its own index space; the top data pin is an address bit.
  // -------------------------------------------------------------------------
  function automatic int key(input sram_host_pkg::pins_s q);
    return wide ? int'(q.addr) : 32'h400000 | int'({q.dout[15], q.addr});
  endfunction
  initial errs = 0;
  assign #1 pd = p;
  assign sel = !p.chip_select_low_n && p.chip_select_high;
  assign wr = sel && !p.write_n
    && (!wide || !(p.upper_lane_enable_n && p.lower_lane_enable_n));
  assign rd = sel && p.write_n;
  always @(pd.addr) ta = $realtime;
  always @(pd.dout) td = $realtime;
  // Setup counts from the edge that ends the overlap; a short setup stores unknowns.
  always @(negedge wr) begin
    ok = ($realtime - ta >= AW) && ($realtime - td >= SD);
    if (!ok) errs++;
    k = key(pd);
    if (!mem.exists(k)) mem[k] = 16'h0000;
    if (wide && !pd.upper_lane_enable_n) mem[k][15:8] = ok ? pd.dout[15:8] : 8'hxx;
    if (!wide || !pd.lower_lane_enable_n) mem[k][7:0] = ok ? pd.dout[7:0] : 8'hxx;
    nw++;
  end
  always @(p or wide or nw) begin
    word = mem.exists(key(p)) ? mem[key(p)] : 16'h0000;
  end
  // -------------------------------------------------------------------------
  // Read path: worst-case access times, junk until valid.
  // -------------------------------------------------------------------------
  assign #(ACC) late = word;
  assign #(ACC) sl = rd;
  assign #(OEA) ol = !p.output_enable_n;
  assign #(ACC) ul = !p.upper_lane_enable_n;
  assign #(ACC) ll = !p.lower_lane_enable_n;
  assign #10 held = word;
  always_comb begin
    v = rd && sl && ol && !p.output_enable_n && (late === word);
    dq_en[15:8] = {8{wide && rd && !p.output_enable_n && !p.upper_lane_enable_n}};
    dq_en[7:0] = {8{rd && !p.output_enable_n && (!wide || !p.lower_lane_enable_n)}};
    dq[15:8] = v && ul ? word[15:8] : held !== word ? held[15:8] : ~late[15:8];
    dq[7:0] = v && (ll || !wide) ? word[7:0] : held !== word ? held[7:0] : ~late[7:0];
  end
endmodule

// ==== bench/sram_host_tb.sv ====
`timescale 1ns/100ps
module sram_host_tb;
  localparam bit SLOW = 1'b1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wide = 1'b1;
  logic ret = 1'b0;
  sram_host_pkg::req_s req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rdata_valid;
  logic [15:0] rdata, dq_in, mdq, men, host_en;
  sram_host_pkg::pins_s pins;
  int merrs;
  int mismatches = 0;
  int num_checks = 0;
  real tcs = 0.0;
  always #25 clk = ~clk;
  sram_host #(.SLOW_GRADE(SLOW)) u_sram_host (.CLK(clk), .RST_B(rst_b), .WIDE_MODE(wide),
    .RETENTION_EXIT(ret), .REQ(req), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .RDATA(rdata), .RDATA_VALID(rdata_valid), .PINS(pins), .DQ_IN(dq_in));
  sram_dev #(.SLOW(SLOW)) u_sram_dev (.p(pins), .wide(wide), .dq(mdq), .dq_en(men),
    .errs(merrs));
  // Two drivers on one bit resolve to unknown, so a clash spoils the read.
  always_comb begin
    host_en = !pins.data_oe ? 16'h0000 : wide || pins.output_enable_n ? 16'hffff : 16'h8000;
    for (int i = 0; i < 16; i++) begin
      // An undriven bit shows the inverse, so sampling a floating bus is caught.
      dq_in[i] = host_en[i] ? (men[i] ? 1'bx : pins.dout[i]) : men[i] ? mdq[i] : ~mdq[i];
    end
  end
  always @(negedge pins.chip_select_low_n) tcs = $realtime;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [20:0] a, input logic [15:0] d,
    input logic [1:0] l, output logic [15:0] q);
    int n;
    @(negedge clk);
    req = '{write: w, addr: a, wdata: d, lanes_n: l};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 60) begin
        chk("ready", 0, 1);
        stop_test();
      end
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    q = 16'hxxxx;
    if (!w) begin
      n = 0;
      while (rdata_valid !== 1'b1) begin
        n++;
        if (n > 60) begin
          chk("rdata_valid", 0, 1);
          stop_test();
        end
        @(negedge clk);
      end
      q = rdata;
    end
  endtask
  task automatic t_reset;
    repeat (2) @(negedge clk);
    chk("cs_low_n", pins.chip_select_low_n, 1);
    chk("cs_high", pins.chip_select_high, 0);
    chk("ready", req_ready, 0);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_wide;
    logic [15:0] q;
    xfer(1'b1, 21'h000000, 16'ha5c3, 2'h0, q);
    xfer(1'b1, 21'h000000, 16'h1e77, 2'h1, q);
    xfer(1'b1, 21'h0fffff, 16'h9d42, 2'h2, q);
    xfer(1'b0, 21'h000000, 16'h0000, 2'h0, q);
    chk("rd_lo_addr", q, 16'h1ec3);
    xfer(1'b0, 21'h0fffff, 16'h0000, 2'h0, q);
    chk("rd_hi_addr", q, 16'h0042);
    $display("t_wide done");
  endtask
  task automatic t_off;
    logic [15:0] q;
    xfer(1'b1, 21'h000000, 16'hffff, 2'h3, q);
    xfer(1'b0, 21'h000000, 16'h0000, 2'h1, q);
    chk("rd_upper", q[15:8], 8'h1e);
    $display("t_off done");
  endtask
  task automatic t_byte;
    logic [15:0] q;
    wide = 1'b0;
    repeat (4) @(negedge clk);
    xfer(1'b1, 21'h100005, 16'h005a, 2'h0, q);
    xfer(1'b1, 21'h000005, 16'h003c, 2'h0, q);
    xfer(1'b0, 21'h100005, 16'h0000, 2'h0, q);
    chk("byte_hi", q[7:0], 8'h5a);
    xfer(1'b0, 21'h000005, 16'h0000, 2'h0, q);
    chk("byte_lo", q[7:0], 8'h3c);
    wide = 1'b1;
    repeat (4) @(negedge clk);
    $display("t_byte done");
  endtask
  task automatic t_ret;
    logic [15:0] q;
    real t0;
    ret = 1'b1;
    repeat (3) @(negedge clk);
    t0 = 0.0;
    fork
      begin
        repeat (2) @(negedge clk);
        ret = 1'b0;
        t0 = $realtime;
      end
      xfer(1'b0, 21'h000000, 16'h0000, 2'h0, q);
    join
    chk("recovery", tcs - t0 >= sram_host_pkg::RECOVERY_NS[SLOW], 1);
    chk("rd_after", q, 16'h1ec3);
    $display("t_ret done");
  endtask
  initial begin
    t_reset();
    t_wide();
    t_off();
    t_byte();
    t_ret();
    chk("setup_faults", 32'(merrs), 0);
    stop_test();
  end
endmodule
